// file: core/pfc_bank.sv
// synthesizer frequency selection, manual calibration starts and test overrides
// assumes register accesses arrive decoded from the serial port, one per cycle,
// and that channel index and power management enable come from other banks
//
// Overview of operation
// R1: 8-bit alternative number picks carrier in 500kHz steps for alternative bands.
// R2: for band 0x8 software uses numbers 0x20 to 0xFF only.
// R3: for band 0x9 software uses numbers 0x00 to 0xBA only.
// R4: band 0x0 uses the standard channel index and ignores the alternative number.
// R5: software writes only 0x0, 0x8 or 0x9 into band bits 3:0.
// R6: writing one to center start launches an 8us calibration, then self-clears.
// R7: center start reads zero once its calibration has finished.
// R8: writing one to delay-cell start launches a 6us calibration, then self-clears.
// R9: delay-cell start reads zero once its calibration has finished.
// R10: test bits always read and write, act only while power management enabled.
// R11: chip source pick selects normal modulation at 0, manual chip level at 1.
// R12: manual chip level gives continuous 0 chips or continuous 1 chips.
// R13: manual TX/RX pick selects receive frequency at 0, transmit at 1.
// R14: frequency mode bit selects normal TX/RX at 0, manual pick at 1.
// R15: both calibrations may run at the same time without blocking.
// R16: a finished manual center calibration raises lock event when enabled.
// R17: upper four band register bits read zero and ignore writes.
// R18: writing zero to a running start bit does not abort its calibration.
`timescale 1ns/10ps
`include "pfc_cfg.svh"

module pfc_bank (
  input  wire logic                  sys_clk,           // system clock, 200 MHz
  input  wire logic                  resetn,            // async reset, active low
  input  wire pfc_pkg::pfc_reg_req_t reg_req,           // register access request
  input  wire logic [4:0]            std_channel,       // standard channel index
  input  wire logic                  power_mgmt_enable, // enables the test bits' effect
  input  wire logic                  lock_evt_enable,   // lock event enabled
  input  wire logic                  normal_chip,       // chip from the modulator
  input  wire logic                  normal_tx_pick,    // tx/rx from the sequencer
  output logic [7:0]                 reg_rdata,         // read data
  output logic                       reg_rd_valid,      // read data valid pulse
  output pfc_pkg::pfc_freq_sel_t     freq_sel,          // synthesizer frequency select
  output logic                       center_cal_run,    // center calibration active
  output logic                       delay_cal_run,     // delay-cell calibration active
  output logic                       synth_lock_evt,    // lock event pulse
  output logic                       mod_chip_out,      // chip value to modulator
  output logic                       synth_tx_pick      // 1 selects transmit frequency
);

  // calibration lengths in clocks, from the typical times at the system clock rate
  localparam logic [`PFC_CNT_W-1:0] CF_CYCLES =
    `PFC_CNT_W'((`PFC_T_CF_NS * `PFC_CLK_MHZ) / `PFC_NS_PER_US);
  localparam logic [`PFC_CNT_W-1:0] DCU_CYCLES =
    `PFC_CNT_W'((`PFC_T_DCU_NS * `PFC_CLK_MHZ) / `PFC_NS_PER_US);

  // merge write data into a register under a mask of writable bits
  function automatic logic [7:0] merge_wr(input logic [7:0] old_v,
                                          input logic [7:0] new_v,
                                          input logic [7:0] mask);
    merge_wr = (old_v & ~mask) | (new_v & mask);
  endfunction : merge_wr

  // one decode for every register strobe, so all addresses compare the same way
  function automatic logic reg_hit(input pfc_pkg::pfc_reg_req_t req,
                                   input logic [5:0]            addr);
    reg_hit = req.wr && (req.addr == addr);
  endfunction : reg_hit

  // a start request is a write to the register that carries a one in the start bit
  function automatic logic go_hit(input pfc_pkg::pfc_reg_req_t req,
                                  input logic                  wr_sel);
    go_hit = wr_sel && req.wdata[`PFC_BIT_GO];
  endfunction : go_hit

  // programmed register contents
  logic [7:0] alt_freq_index_ff;
  logic [3:0] freq_band_code_ff;
  logic [6:0] center_cal_value_ff;
  logic [5:0] delay_cal_low_ff;
  logic [7:0] mod_test_ff;

  // output flip-flops
  logic [7:0] reg_rdata_ff;
  logic       reg_rd_valid_ff;
  logic       synth_lock_evt_ff;
  logic       mod_chip_ff;
  logic       synth_tx_pick_ff;
  logic       center_cal_run_ff;
  logic       delay_cal_run_ff;
  pfc_pkg::pfc_freq_sel_t freq_sel_ff;

  // next values and write strobes
  pfc_pkg::pfc_freq_sel_t nxt_freq_sel;
  logic [7:0] nxt_rdata;
  logic [7:0] tst_eff;
  logic       wr_alt;
  logic       wr_band;
  logic       wr_cf;
  logic       wr_dcu;
  logic       wr_tst;
  logic       center_cal_go;
  logic       delay_cal_go;

  // calibration timer status
  logic       cf_busy;
  logic       cf_done;
  logic       dcu_busy;
  logic       dcu_done;

  // write strobes per register
  // an unmapped address matches no strobe, so such writes are dropped
  assign wr_alt  = reg_hit(reg_req, `PFC_ADDR_ALT_NUM);
  assign wr_band = reg_hit(reg_req, `PFC_ADDR_BAND);
  assign wr_cf   = reg_hit(reg_req, `PFC_ADDR_CF);
  assign wr_dcu  = reg_hit(reg_req, `PFC_ADDR_DCU);
  assign wr_tst  = reg_hit(reg_req, `PFC_ADDR_TST);

  // only a written one starts; a written zero never aborts a running cycle
  assign center_cal_go = go_hit(reg_req, wr_cf);   // see R6 see R18
  assign delay_cal_go  = go_hit(reg_req, wr_dcu);  // see R8 see R18

  // independent timers, so both calibrations can overlap
  // two small counters cost a few flops but keep one loop from queuing behind the other
  pfc_cal_timer #(
    .CYCLES (CF_CYCLES)
  ) u_center_timer (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .start   (center_cal_go),  // see R6 see R15
    .busy    (cf_busy),
    .done    (cf_done)
  );

  pfc_cal_timer #(
    .CYCLES (DCU_CYCLES)
  ) u_delay_timer (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .start   (delay_cal_go),   // see R8 see R15
    .busy    (dcu_busy),
    .done    (dcu_done)
  );

  // alternative frequency number, every value is stored as written
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      alt_freq_index_ff <= `PFC_RST_ALT_NUM;
    end else if (wr_alt) begin
      alt_freq_index_ff <= reg_req.wdata;  // see R1
    end
  end

  // band code; upper nibble is not stored at all
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      freq_band_code_ff <= `PFC_RST_BAND;
    end else if (wr_band) begin
      freq_band_code_ff <= reg_req.wdata[`PFC_BAND_W-1:0];  // see R17
    end
  end

  // low bits of the center register; its start bit lives in the center timer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      center_cal_value_ff <= `PFC_RST_CF_LOW;
    end else if (wr_cf) begin
      center_cal_value_ff <= reg_req.wdata[`PFC_CF_LOW_W-1:0];
    end
  end

  // low bits of the delay-cell register; the read-only bit above them is not stored
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      delay_cal_low_ff <= `PFC_RST_DCU_LOW;
    end else if (wr_dcu) begin
      delay_cal_low_ff <= reg_req.wdata[`PFC_DCU_LOW_W-1:0];
    end
  end

  // test register is always accessible, whatever the power state
  // the gate sits after the register, so readback never depends on power state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mod_test_ff <= `PFC_RST_TST;
    end else if (wr_tst) begin
      mod_test_ff <= merge_wr(mod_test_ff, reg_req.wdata, 8'hff);  // see R10
    end
  end

  // read mux; the start bits show the live timer state
  always_comb begin
    nxt_rdata = `PFC_RD_IDLE;
    case (reg_req.addr)
      `PFC_ADDR_ALT_NUM: nxt_rdata = alt_freq_index_ff;
      `PFC_ADDR_BAND:    nxt_rdata = merge_wr(`PFC_RD_IDLE, {4'h0, freq_band_code_ff},
                                              `PFC_MASK_BAND);  // see R17
      `PFC_ADDR_CF:      nxt_rdata = {cf_busy, center_cal_value_ff};  // see R7 see R18
      `PFC_ADDR_DCU:     nxt_rdata = {dcu_busy, 1'b0, delay_cal_low_ff};  // see R9 see R18
      `PFC_ADDR_TST:     nxt_rdata = mod_test_ff;  // see R10
      // unmapped addresses read as zero
      default:           nxt_rdata = `PFC_RD_IDLE;
    endcase
  end

  // read valid follows every read request by exactly one cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rd_valid_ff <= 1'b0;
    end else begin
      reg_rd_valid_ff <= reg_req.rd;
    end
  end

  // read data is registered and holds until the next read
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_ff <= `PFC_RD_IDLE;
    end else if (reg_req.rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // frequency selection: band zero falls back to the standard channel
  // reserved bands pass on as written; keeping them legal is up to software
  always_comb begin
    nxt_freq_sel.band    = freq_band_code_ff;
    nxt_freq_sel.channel = std_channel;
    if (freq_band_code_ff == `PFC_BAND_STD) begin
      nxt_freq_sel.use_alt        = 1'b0;                // see R4
      nxt_freq_sel.alt_freq_index = `PFC_RST_ALT_NUM;   // see R4
    end else begin
      nxt_freq_sel.use_alt        = 1'b1;                // see R1
      nxt_freq_sel.alt_freq_index = alt_freq_index_ff;  // see R1
    end
  end

  // registered so the synthesizer never sees a half-updated band and number
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      freq_sel_ff <= '0;
    end else begin
      freq_sel_ff <= nxt_freq_sel;
    end
  end

  // center run flag, registered from the timer busy in step with the start bit readback
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      center_cal_run_ff <= 1'b0;
    end else begin
      center_cal_run_ff <= cf_busy;  // see R6
    end
  end

  // delay-cell run flag, independent of the center loop
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      delay_cal_run_ff <= 1'b0;
    end else begin
      delay_cal_run_ff <= dcu_busy;  // see R8 see R15
    end
  end

  // lock event: one pulse per finished center cycle, none while masked
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      synth_lock_evt_ff <= 1'b0;
    end else begin
      synth_lock_evt_ff <= cf_done && lock_evt_enable;  // see R16
    end
  end

  // test bits act only with power management on, else reset values apply
  // dropping power management takes effect on the next clock, not mid-chip
  assign tst_eff = power_mgmt_enable ? mod_test_ff : `PFC_RST_TST;  // see R10

  // modulation chip: manual level only when the gated test bits ask for it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mod_chip_ff <= 1'b0;
    end else if (tst_eff[`PFC_BIT_CHIP_PICK]) begin
      mod_chip_ff <= tst_eff[`PFC_BIT_CHIP_LVL];  // see R11 see R12
    end else begin
      mod_chip_ff <= normal_chip;  // see R11
    end
  end

  // tx/rx frequency pick: manual pick only in manual frequency mode
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      synth_tx_pick_ff <= 1'b0;
    end else if (tst_eff[`PFC_BIT_FREQ_MODE]) begin
      synth_tx_pick_ff <= tst_eff[`PFC_BIT_TXRX_PICK];  // see R13 see R14
    end else begin
      synth_tx_pick_ff <= normal_tx_pick;  // see R14
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata      = reg_rdata_ff;
  assign reg_rd_valid   = reg_rd_valid_ff;
  assign freq_sel       = freq_sel_ff;
  assign center_cal_run = center_cal_run_ff;
  assign delay_cal_run  = delay_cal_run_ff;
  assign synth_lock_evt = synth_lock_evt_ff;
  assign mod_chip_out   = mod_chip_ff;
  assign synth_tx_pick  = synth_tx_pick_ff;

endmodule : pfc_bank

// file: core/pfc_cfg.svh
// constants for the synthesizer frequency and calibration control bank
// assumes a 200 MHz system clock and a 6-bit register address
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

// register addresses
`define PFC_ADDR_ALT_NUM   6'h13
`define PFC_ADDR_BAND      6'h14
`define PFC_ADDR_CF        6'h1a
`define PFC_ADDR_DCU       6'h1b
`define PFC_ADDR_TST       6'h3d

// reset values
`define PFC_RST_ALT_NUM    8'h00
`define PFC_RST_BAND       4'h0
`define PFC_RST_CF_LOW     7'h57
`define PFC_RST_DCU_LOW    6'h20
`define PFC_RST_TST        8'h00
`define PFC_RD_IDLE        8'h00

// field positions and masks
`define PFC_BIT_GO         7
`define PFC_BIT_CHIP_PICK  7
`define PFC_BIT_CHIP_LVL   6
`define PFC_BIT_TXRX_PICK  5
`define PFC_BIT_FREQ_MODE  4
`define PFC_BAND_STD       4'h0
`define PFC_MASK_BAND      8'h0f
`define PFC_MASK_CF        8'h7f
`define PFC_MASK_DCU       8'h3f
`define PFC_BAND_W         4
`define PFC_CF_LOW_W       7
`define PFC_DCU_LOW_W      6

// timing
`define PFC_CLK_MHZ        200
`define PFC_T_CF_NS        8000
`define PFC_T_DCU_NS       6000
`define PFC_NS_PER_US      1000
`define PFC_CNT_W          11

`endif

// file: core/pfc_pkg.sv
// types shared by the frequency and calibration control bank
// assumes pfc_cfg.svh supplies the numeric constants
package pfc_pkg;

  // one register access from the serial register port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } pfc_reg_req_t;

  // frequency selection handed to the synthesizer
  typedef struct packed {
    logic       use_alt;
    logic [3:0] band;
    logic [7:0] alt_freq_index;
    logic [4:0] channel;
  } pfc_freq_sel_t;

  // calibration timer states
  typedef enum logic [1:0] {
    PFC_TMR_IDLE = 2'b01,
    PFC_TMR_RUN  = 2'b10
  } pfc_tmr_state_t;

endpackage : pfc_pkg

// file: core/pfc_cal_timer.sv
// calibration cycle timer: runs a fixed number of clocks after a start pulse
// assumes start is a one-cycle pulse in the sys_clk domain
`timescale 1ns/10ps
`include "pfc_cfg.svh"

module pfc_cal_timer #(
  parameter logic [`PFC_CNT_W-1:0] CYCLES = `PFC_CNT_W'h1
) (
  input  wire logic sys_clk, // system clock
  input  wire logic resetn,  // async reset, active low
  input  wire logic start,   // start request pulse
  output logic      busy,    // calibration running
  output logic      done     // one-cycle pulse at completion
);

  pfc_pkg::pfc_tmr_state_t  state_ff;
  pfc_pkg::pfc_tmr_state_t  nxt_state;
  logic [`PFC_CNT_W-1:0]    cnt_ff;
  logic [`PFC_CNT_W-1:0]    nxt_cnt;
  logic                     last;

  assign last = (cnt_ff == CYCLES - `PFC_CNT_W'h1);

  // a start during the final cycle reloads, so the new request is not lost
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      pfc_pkg::PFC_TMR_IDLE: begin
        if (start) begin
          nxt_state = pfc_pkg::PFC_TMR_RUN;
          nxt_cnt   = '0;
        end
      end
      pfc_pkg::PFC_TMR_RUN: begin
        if (last && start) begin
          nxt_cnt = '0;
        end else if (last) begin
          nxt_state = pfc_pkg::PFC_TMR_IDLE;
        end else begin
          nxt_cnt = cnt_ff + `PFC_CNT_W'h1;
        end
      end
      default: begin
        nxt_state = pfc_pkg::PFC_TMR_IDLE;
        nxt_cnt   = '0;
      end
    endcase
  end

  // state and cycle counter
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= pfc_pkg::PFC_TMR_IDLE;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign busy = (state_ff == pfc_pkg::PFC_TMR_RUN);
  assign done = busy && last;

endmodule : pfc_cal_timer

// file: dv/pfc_bank_assertions.sv
// checker for the frequency and calibration control bank
// assumes it is bound onto pfc_bank and sees only that module's ports
`timescale 1ns/10ps
`include "pfc_cfg.svh"

module pfc_bank_chk (
  input wire logic                   sys_clk,           // clock
  input wire logic                   resetn,            // reset, active low
  input wire pfc_pkg::pfc_reg_req_t  reg_req,           // access request
  input wire logic [4:0]             std_channel,       // channel index
  input wire logic                   power_mgmt_enable, // test gate
  input wire logic                   lock_evt_enable,   // event gate
  input wire logic                   normal_chip,       // normal chip
  input wire logic                   normal_tx_pick,    // normal tx/rx
  input wire logic [7:0]             reg_rdata,         // read data
  input wire logic                   reg_rd_valid,      // read valid
  input wire pfc_pkg::pfc_freq_sel_t freq_sel,          // frequency select
  input wire logic                   center_cal_run,    // center active
  input wire logic                   delay_cal_run,     // delay active
  input wire logic                   synth_lock_evt,    // lock event
  input wire logic                   mod_chip_out,      // chip out
  input wire logic                   synth_tx_pick      // tx pick
);
  logic [10:0] cen_len_ff; // cycles the center run flag has been high
  logic [10:0] dly_len_ff; // cycles the delay run flag has been high

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // run length counters, cleared while idle so each cycle is measured alone
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cen_len_ff <= 11'h000;
      dly_len_ff <= 11'h000;
    end else begin
      cen_len_ff <= center_cal_run ? cen_len_ff + 11'h001 : 11'h000;
      dly_len_ff <= delay_cal_run ? dly_len_ff + 11'h001 : 11'h000;
    end
  end

  center_start_a:
    assert property (reg_req.wr && reg_req.addr == `PFC_ADDR_CF && reg_req.wdata[7]
      && !center_cal_run |=> ##1 center_cal_run) else $error("center start lost");
  delay_start_a:
    assert property (reg_req.wr && reg_req.addr == `PFC_ADDR_DCU && reg_req.wdata[7]
      && !delay_cal_run |=> ##1 delay_cal_run) else $error("delay start lost");
  center_len_a:
    assert property ($fell(center_cal_run) |-> cen_len_ff == 11'h640)
      else $error("center cycle length wrong");
  delay_len_a:
    assert property ($fell(delay_cal_run) |-> dly_len_ff == 11'h4b0)
      else $error("delay cycle length wrong");
  lock_pulse_a:
    assert property (synth_lock_evt |-> center_cal_run ##1 !center_cal_run)
      else $error("lock event out of place");
  read_valid_a:
    assert property (reg_rd_valid == $past(reg_req.rd)) else $error("read valid wrong");
  alt_flag_a:
    assert property (freq_sel.use_alt == (freq_sel.band != 4'h0)) else $error("use_alt wrong");
  std_band_a:
    assert property (freq_sel.band == 4'h0 && $past(resetn) |-> freq_sel.alt_freq_index
      == 8'h00 && freq_sel.channel == $past(std_channel)) else $error("standard band wrong");
  test_gate_a:
    assert property (!power_mgmt_enable |=> mod_chip_out == $past(normal_chip)
      && synth_tx_pick == $past(normal_tx_pick)) else $error("test bits leak");
endmodule : pfc_bank_chk

bind pfc_bank pfc_bank_chk u_pfc_bank_chk (
  .sys_clk           (sys_clk),
  .resetn            (resetn),
  .reg_req           (reg_req),
  .std_channel       (std_channel),
  .power_mgmt_enable (power_mgmt_enable),
  .lock_evt_enable   (lock_evt_enable),
  .normal_chip       (normal_chip),
  .normal_tx_pick    (normal_tx_pick),
  .reg_rdata         (reg_rdata),
  .reg_rd_valid      (reg_rd_valid),
  .freq_sel          (freq_sel),
  .center_cal_run    (center_cal_run),
  .delay_cal_run     (delay_cal_run),
  .synth_lock_evt    (synth_lock_evt),
  .mod_chip_out      (mod_chip_out),
  .synth_tx_pick     (synth_tx_pick)
);

// file: dv/pfc_tb.sv
// self-checking bench for the frequency and calibration control bank
// assumes the checker is bound in from its own file
`timescale 1ns/10ps
`include "pfc_cfg.svh"

module testbench;
  logic sys_clk, resetn, power_mgmt_enable, lock_evt_enable, normal_chip, normal_tx_pick;
  logic reg_rd_valid, center_cal_run, delay_cal_run, synth_lock_evt, mod_chip_out;
  logic synth_tx_pick;
  logic [4:0] std_channel;
  logic [7:0] reg_rdata, rd_val;
  pfc_pkg::pfc_reg_req_t reg_req;
  pfc_pkg::pfc_freq_sel_t freq_sel;
  int fail_count, comparisons;
  int lock_count = 0;

  pfc_bank u_pfc_bank (.sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req),
    .std_channel(std_channel), .power_mgmt_enable(power_mgmt_enable),
    .lock_evt_enable(lock_evt_enable), .normal_chip(normal_chip),
    .normal_tx_pick(normal_tx_pick), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .freq_sel(freq_sel), .center_cal_run(center_cal_run), .delay_cal_run(delay_cal_run),
    .synth_lock_evt(synth_lock_evt), .mod_chip_out(mod_chip_out),
    .synth_tx_pick(synth_tx_pick));

  always #2.5 sys_clk = ~sys_clk;
  // the lock event is a single pulse, so count pulses for later inspection
  always @(posedge sys_clk) if (synth_lock_evt === 1'b1) lock_count <= lock_count + 1;

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : chk
  // idle the port, then let n edges pass
  task automatic wait_cyc(input int n);
    reg_req = '0;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_cyc
  // strobes stay up between back-to-back calls; wait_cyc drops them
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    #1;
    chk("read valid", 8'h01, {7'h00, reg_rd_valid});
    d = reg_rdata;
  endtask : rd
  task automatic t_reset();
    logic [5:0] addrs [6] = '{`PFC_ADDR_ALT_NUM, `PFC_ADDR_BAND, `PFC_ADDR_CF,
                              `PFC_ADDR_DCU, `PFC_ADDR_TST, 6'h30};
    logic [7:0] exps [6] = '{8'h00, 8'h00, 8'h57, 8'h20, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rd(addrs[i], rd_val);
      chk("reset value", exps[i], rd_val);
    end
  endtask : t_reset
  task automatic t_band();
    logic [3:0] bands [3] = '{4'h8, 4'h9, 4'h0};
    logic [7:0] nums [3] = '{8'h20, 8'hba, 8'h55};
    for (int i = 0; i < 3; i++) begin
      wr(`PFC_ADDR_ALT_NUM, nums[i]);
      wr(`PFC_ADDR_BAND, {4'hf, bands[i]});
      wait_cyc(1);
      chk("use alt", {7'h00, bands[i] != 4'h0}, {7'h00, freq_sel.use_alt});
      chk("band out", {4'h0, bands[i]}, {4'h0, freq_sel.band});
      chk("alt index", (bands[i] != 4'h0) ? nums[i] : 8'h00, freq_sel.alt_freq_index);
      rd(`PFC_ADDR_BAND, rd_val);
      chk("band readback", {4'h0, bands[i]}, rd_val);
    end
    std_channel = 5'h1a;
    wait_cyc(1);
    chk("std channel", 8'h1a, {3'h0, freq_sel.channel});
    chk("alt ignored", 8'h00, freq_sel.alt_freq_index);
    wr(6'h30, 8'hff);
    rd(6'h30, rd_val);
    chk("unmapped", 8'h00, rd_val);
  endtask : t_band
  // both loops at once, a zero write mid-run, exact self-clear edges
  task automatic t_cal();
    int lock_base;
    lock_base = lock_count;
    wr(`PFC_ADDR_CF, 8'hd7);
    wr(`PFC_ADDR_DCU, 8'ha0);
    wr(`PFC_ADDR_CF, 8'h57);
    rd(`PFC_ADDR_CF, rd_val);
    chk("center go held", 8'hd7, rd_val);
    chk("both running", 8'h03, {6'h00, center_cal_run, delay_cal_run});
    wait_cyc(1197);
    rd(`PFC_ADDR_DCU, rd_val);
    chk("delay last busy", 8'ha0, rd_val);
    rd(`PFC_ADDR_DCU, rd_val);
    chk("delay cleared", 8'h20, rd_val);
    wait_cyc(397);
    rd(`PFC_ADDR_CF, rd_val);
    chk("center last busy", 8'hd7, rd_val);
    rd(`PFC_ADDR_CF, rd_val);
    chk("center cleared", 8'h57, rd_val);
    wait_cyc(2);
    chk("lock event", 8'h01, 8'(lock_count - lock_base));
    lock_evt_enable = 1'b0;
    lock_base = lock_count;
    wr(`PFC_ADDR_CF, 8'hd7);
    wait_cyc(1605);
    chk("lock masked", 8'h00, 8'(lock_count - lock_base));
  endtask : t_cal
  task automatic t_test();
    logic [7:0] vals [6] = '{8'h00, 8'hc0, 8'h80, 8'h30, 8'h10, 8'hf0};
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 6; i++) begin
        power_mgmt_enable = p[0];
        normal_chip = ~vals[i][6];
        normal_tx_pick = ~vals[i][5];
        wr(`PFC_ADDR_TST, vals[i]);
        wait_cyc(1);
        chk("chip out", {7'h00, (p[0] & vals[i][7]) ? vals[i][6] : ~vals[i][6]},
            {7'h00, mod_chip_out});
        chk("tx pick", {7'h00, (p[0] & vals[i][4]) ? vals[i][5] : ~vals[i][5]},
            {7'h00, synth_tx_pick});
        rd(`PFC_ADDR_TST, rd_val);
        chk("test readback", vals[i], rd_val);
      end
    end
  endtask : t_test
  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    reg_req = '0;
    std_channel = 5'h0b;
    power_mgmt_enable = 1'b0;
    lock_evt_enable = 1'b1;
    normal_chip = 1'b0;
    normal_tx_pick = 1'b0;
    fail_count = 0;
    comparisons = 0;
    repeat (3) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_band();
    t_cal();
    t_test();
    finish_test();
  end
  // guard against a hang anywhere in the sequence
  initial begin
    #400000;
    fail_count++;
    finish_test();
  end
endmodule : testbench
